/* common/adc_cfg_pkg.sv */
/*
 Constants for the converter configuration and status register slice.
 Assumes an external serial control port engine presents byte-wide register
 read and write strobes in the ref_clk domain.
*/
// Behaviour
// - Read-only 24-bit SYSREF capture position word
// - 16-bit full-scale word, reset 0xA000, all channels
// - Power code resets 0x4B; 0x46 low power
// - Timestamp control bit 0 enables input receiver
// - Timestamp control bit 1 selects PECL mode
// - Reference output on when enable and PLL
package adc_cfg_pkg;
	localparam logic [7:0] ADDR_POS_0 = 8'h2C;
	localparam logic [7:0] ADDR_POS_1 = 8'h2D;
	localparam logic [7:0] ADDR_POS_2 = 8'h2E;
	localparam logic [7:0] ADDR_FS_0 = 8'h30;
	localparam logic [7:0] ADDR_FS_1 = 8'h31;
	localparam logic [7:0] ADDR_POWER = 8'h37;
	localparam logic [7:0] ADDR_TSTAMP = 8'h3B;
	localparam logic [7:0] ADDR_REFOUT = 8'h3C;
	localparam logic [7:0] ADDR_FBDIV_A = 8'h3D;
	localparam logic [15:0] FS_RESET = 16'hA000;
	localparam logic [7:0] POWER_RESET = 8'h4B;
	localparam logic [7:0] POWER_LOW = 8'h46;
	localparam logic [7:0] POWER_HIGH = 8'h4B;
	localparam logic [7:0] TSTAMP_RESET = 8'h00;
	localparam logic [7:0] REFOUT_RESET = 8'h01;
	localparam logic [7:0] FBDIV_A_RESET = 8'h00;
	localparam int TSTAMP_EN_BIT = 0;
	localparam int TSTAMP_PECL_BIT = 1;
	localparam int REFOUT_EN_BIT = 0;
	localparam int POS_WIDTH = 24;
	localparam int FS_WIDTH = 16;
endpackage : adc_cfg_pkg

/* rtl/adc_config_status_regs.sv */
/*
 Configuration and status register slice of the converter.
 Assumes the serial control port decoder supplies one-cycle byte strobes on
 ref_clk; the capture position word comes from the SYSREF detector.
*/
`timescale 1ns/100ps
module adc_config_status_regs
	import adc_cfg_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [23:0] sysref_edge_position,
	input wire logic pll_enable,
	output logic [15:0] full_scale_adjust,
	output logic [7:0] power_profile_code,
	output logic power_low_selected,
	output logic timestamp_input_enable,
	output logic timestamp_pecl_mode,
	output logic reference_clock_output_enable,
	output logic [7:0] feedback_divider_a
);

	logic [23:0] pos_s1_reg;
	logic [23:0] pos_s2_reg;
	logic [23:0] pos_s3_reg;
	logic [23:0] pos_hold_reg;
	logic [15:0] fs_reg;
	logic [7:0] power_reg;
	logic [7:0] tstamp_reg;
	logic [7:0] refout_reg;
	logic [7:0] fbdiv_reg;
	logic pll_s1_reg;
	logic pll_s2_reg;
	logic [7:0] rdata_next;

	// Position word and PLL enable come from other clocking; two-flop them
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			pos_s1_reg <= '0;
			pos_s2_reg <= '0;
			pll_s1_reg <= 1'b0;
			pll_s2_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			pos_s1_reg <= sysref_edge_position;
			pos_s2_reg <= pos_s1_reg;
			pll_s1_reg <= pll_enable;
			pll_s2_reg <= pll_s1_reg;
		end

	// A word caught while it changes could mix bits of two captures;
	// take it only once two samples in a row agree
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			pos_s3_reg <= '0;
			pos_hold_reg <= '0;
		end
		else if (clk_en)
		begin
			pos_s3_reg <= pos_s2_reg;
			if (pos_s2_reg == pos_s3_reg)
				pos_hold_reg <= pos_s3_reg;
		end

	// Writable registers; position addresses decode to nothing here
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			fs_reg <= FS_RESET;
			power_reg <= POWER_RESET;
			tstamp_reg <= TSTAMP_RESET;
			refout_reg <= REFOUT_RESET;
			fbdiv_reg <= FBDIV_A_RESET;
		end
		else if (clk_en && reg_wr)
		begin
			case (reg_addr)
				ADDR_FS_0: fs_reg[7:0] <= reg_wdata;
				ADDR_FS_1: fs_reg[15:8] <= reg_wdata;
				ADDR_POWER: power_reg <= reg_wdata;
				ADDR_TSTAMP: tstamp_reg <= reg_wdata;
				ADDR_REFOUT: refout_reg <= reg_wdata;
				ADDR_FBDIV_A: fbdiv_reg <= reg_wdata;
				default: ;
			endcase
		end

	always_comb
	begin
		rdata_next = 8'h00;
		case (reg_addr)
			ADDR_POS_0: rdata_next = pos_hold_reg[7:0];
			ADDR_POS_1: rdata_next = pos_hold_reg[15:8];
			ADDR_POS_2: rdata_next = pos_hold_reg[23:16];
			ADDR_FS_0: rdata_next = fs_reg[7:0];
			ADDR_FS_1: rdata_next = fs_reg[15:8];
			ADDR_POWER: rdata_next = power_reg;
			ADDR_TSTAMP: rdata_next = tstamp_reg;
			ADDR_REFOUT: rdata_next = refout_reg;
			ADDR_FBDIV_A: rdata_next = fbdiv_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else if (clk_en)
		begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= rdata_next;
		end

	// Control outputs, registered from the bank
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			full_scale_adjust <= FS_RESET;
			power_profile_code <= POWER_RESET;
			power_low_selected <= 1'b0;
			timestamp_input_enable <= 1'b0;
			timestamp_pecl_mode <= 1'b0;
			reference_clock_output_enable <= 1'b0;
			feedback_divider_a <= FBDIV_A_RESET;
		end
		else if (clk_en)
		begin
			full_scale_adjust <= fs_reg;
			power_profile_code <= power_reg;
			power_low_selected <= (power_reg == POWER_LOW);
			timestamp_input_enable <= tstamp_reg[TSTAMP_EN_BIT];
			timestamp_pecl_mode <= tstamp_reg[TSTAMP_PECL_BIT];
			reference_clock_output_enable <= refout_reg[REFOUT_EN_BIT] & pll_s2_reg;
			feedback_divider_a <= fbdiv_reg;
		end

	// A byte write reaches its control output one enabled edge after the write edge
	AST_FS_FOLLOWS: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && reg_wr && reg_addr == ADDR_FS_1 ##1 clk_en |=> full_scale_adjust[15:8] == $past(reg_wdata, 2))
		else $error("full scale high byte not applied");

	AST_FS_LOW: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && reg_wr && reg_addr == ADDR_FS_0 ##1 clk_en |=> full_scale_adjust[7:0] == $past(reg_wdata, 2))
		else $error("full scale low byte not applied");

	AST_FS_RESET: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(reset) |-> full_scale_adjust == FS_RESET)
		else $error("full scale word not at its default after reset");

	AST_POWER_CODE: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && reg_wr && reg_addr == ADDR_POWER ##1 clk_en |=> power_profile_code == $past(reg_wdata, 2))
		else $error("power code not applied");

	AST_POWER_LOW: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en |=> power_low_selected == ($past(power_reg) == POWER_LOW))
		else $error("low power flag wrong");

	AST_POWER_RESET: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(reset) |-> power_profile_code == POWER_RESET && !power_low_selected)
		else $error("power code not at its default after reset");

	AST_POWER_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
		!(reg_wr && reg_addr == ADDR_POWER) |=> $stable(power_reg))
		else $error("power code changed without write");

	AST_TS_EN: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && reg_wr && reg_addr == ADDR_TSTAMP ##1 clk_en
		|=> timestamp_input_enable == $past(reg_wdata[TSTAMP_EN_BIT], 2))
		else $error("timestamp enable not applied");

	AST_TS_PECL: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && reg_wr && reg_addr == ADDR_TSTAMP ##1 clk_en
		|=> timestamp_pecl_mode == $past(reg_wdata[TSTAMP_PECL_BIT], 2))
		else $error("timestamp pecl mode not applied");

	AST_TS_RESET: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(reset) |-> !timestamp_input_enable && !timestamp_pecl_mode)
		else $error("timestamp controls not cleared by reset");

	// Output follows the enable bit and the synchronised PLL enable together
	AST_REFOUT: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en |=> reference_clock_output_enable == ($past(pll_s2_reg) && $past(refout_reg[REFOUT_EN_BIT])))
		else $error("reference output does not follow its enables");

	AST_REFOUT_RESET: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(reset) |-> refout_reg[REFOUT_EN_BIT])
		else $error("reference output enable not set after reset");

	AST_POS_RO: assert property (@(posedge ref_clk) disable iff (reset)
		reg_wr && (reg_addr == ADDR_POS_0 || reg_addr == ADDR_POS_1 || reg_addr == ADDR_POS_2)
		|=> $stable(fs_reg) && $stable(power_reg) && $stable(tstamp_reg)
		&& $stable(refout_reg) && $stable(fbdiv_reg))
		else $error("position write changed state");

	AST_POS_READ: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && reg_rd && reg_addr == ADDR_POS_2 |=> reg_rvalid && reg_rdata == $past(pos_hold_reg[23:16]))
		else $error("position high byte read wrong");

	AST_POS_READ_LOW: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && reg_rd && reg_addr == ADDR_POS_0 |=> reg_rvalid && reg_rdata == $past(pos_hold_reg[7:0]))
		else $error("position low byte read wrong");

	AST_POS_FILTER: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && pos_s2_reg != pos_s3_reg |=> $stable(pos_hold_reg))
		else $error("position word taken while still changing");

	// Main scenarios worth seeing at least once
	COV_LOW: cover property (@(posedge ref_clk) disable iff (reset) power_low_selected);
	COV_REF: cover property (@(posedge ref_clk) disable iff (reset) reference_clock_output_enable);
	COV_POS: cover property (@(posedge ref_clk) disable iff (reset) reg_rvalid && reg_rdata != 8'h00);
	COV_FS_MAX: cover property (@(posedge ref_clk) disable iff (reset) &full_scale_adjust);
	COV_PECL: cover property (@(posedge ref_clk) disable iff (reset) timestamp_pecl_mode && !timestamp_input_enable);

endmodule : adc_config_status_regs

/* testbench/test_adc_config_status_regs.sv */
/*
 Self-checking bench for the configuration and status register slice.
 Assumes byte strobes taken on rising ref_clk edges; stimulus moves on falling edges.
*/
`timescale 1ns/100ps
module test_adc_config_status_regs
	import adc_cfg_pkg::*;
;
	logic ref_clk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, pll_enable = 1, reg_rvalid;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, power_profile_code, feedback_divider_a;
	logic [23:0] sysref_edge_position = 24'hABCDEF;
	logic [15:0] full_scale_adjust;
	logic power_low_selected, timestamp_input_enable, timestamp_pecl_mode, reference_clock_output_enable;
	int failures = 0, cmp_count = 0;
	always #2 ref_clk = ~ref_clk;
	adc_config_status_regs adc_config_status_regs_inst (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .sysref_edge_position(sysref_edge_position), .pll_enable(pll_enable),
		.full_scale_adjust(full_scale_adjust), .power_profile_code(power_profile_code),
		.power_low_selected(power_low_selected), .timestamp_input_enable(timestamp_input_enable),
		.timestamp_pecl_mode(timestamp_pecl_mode), .reference_clock_output_enable(reference_clock_output_enable),
		.feedback_divider_a(feedback_divider_a));
	task automatic end_sim();
		$display("failures %0d comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		repeat (2) @(negedge ref_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		int n;
		@(negedge ref_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 4)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 4)
		begin
			failures++;
			$display("[ERR] %0t read answer timed out", $time);
			end_sim();
		end
		else
		begin
			check({16'h0000, reg_rdata}, {16'h0000, exp});
			@(negedge ref_clk);
			check({23'h0, reg_rvalid}, 24'h000000);
		end
	endtask : rd
	initial
	begin
		repeat (10) @(negedge ref_clk);
		reset = 1'b0;
		rd(ADDR_FS_0, 8'h00);
		rd(ADDR_FS_1, 8'hA0);
		rd(ADDR_POWER, 8'h4B);
		check({15'h0, power_low_selected, power_profile_code}, {16'h0000, POWER_HIGH});
		rd(ADDR_TSTAMP, 8'h00);
		rd(ADDR_REFOUT, 8'h01);
		check({23'h0, reference_clock_output_enable}, 24'h000001);
		rd(ADDR_FBDIV_A, 8'h00);
		rd(ADDR_POS_0, 8'hEF);
		rd(ADDR_POS_1, 8'hCD);
		rd(ADDR_POS_2, 8'hAB);
		wr(ADDR_POS_1, 8'h55);
		rd(ADDR_POS_1, 8'hCD);
		check({8'h00, full_scale_adjust}, 24'h00A000);
		wr(ADDR_FS_0, 8'hFF);
		wr(ADDR_FS_1, 8'hFF);
		check({8'h00, full_scale_adjust}, 24'h00FFFF);
		rd(ADDR_FS_1, 8'hFF);
		// Companion power registers, calibration and link enables sit outside this slice
		wr(ADDR_POWER, 8'h46);
		check({15'h0, power_low_selected, power_profile_code}, 24'h000146);
		wr(ADDR_TSTAMP, 8'h01);
		check({22'h0, timestamp_pecl_mode, timestamp_input_enable}, 24'h000001);
		wr(ADDR_TSTAMP, 8'h02);
		check({22'h0, timestamp_pecl_mode, timestamp_input_enable}, 24'h000002);
		rd(ADDR_TSTAMP, 8'h02);
		wr(ADDR_FBDIV_A, 8'h05);
		check({16'h0000, feedback_divider_a}, 24'h000005);
		rd(ADDR_FBDIV_A, 8'h05);
		pll_enable = 1'b0;
		repeat (4) @(negedge ref_clk);
		check({23'h0, reference_clock_output_enable}, 24'h000000);
		pll_enable = 1'b1;
		wr(ADDR_REFOUT, 8'h00);
		repeat (2) @(negedge ref_clk);
		check({23'h0, reference_clock_output_enable}, 24'h000000);
		// A write with the clock enable low must leave the power code alone
		clk_en = 1'b0;
		wr(ADDR_POWER, 8'h4B);
		clk_en = 1'b1;
		check({16'h0000, power_profile_code}, 24'h000046);
		// Reset in mid-run brings every control back to its default
		reset = 1'b1;
		@(negedge ref_clk);
		check({8'h00, full_scale_adjust}, {8'h00, FS_RESET});
		check({15'h0, power_low_selected, power_profile_code}, {16'h0000, POWER_RESET});
		check({22'h0, timestamp_pecl_mode, timestamp_input_enable}, 24'h000000);
		check({23'h0, reference_clock_output_enable}, 24'h000000);
		reset = 1'b0;
		repeat (4) @(negedge ref_clk);
		check({23'h0, reference_clock_output_enable}, 24'h000001);
		rd(ADDR_REFOUT, 8'h01);
		end_sim();
	end
endmodule : test_adc_config_status_regs
